// File: verilog/usf_pkg.sv
// Package of constants and carrier types for the serial port core.
package usf_pkg;
    localparam int DATA_W = 8;
    localparam int DIV_W = 8;
    localparam int TICK_W = 5;
    localparam logic [2:0] BT_16 = 3'h0;
    localparam logic [2:0] BT_16_17 = 3'h1;
    localparam logic [2:0] BT_15 = 3'h2;
    localparam logic [2:0] BT_15_16 = 3'h3;
    localparam logic [2:0] BT_17 = 3'h4;
    localparam logic [TICK_W-1:0] TICKS_15 = 5'h0f;
    localparam logic [TICK_W-1:0] TICKS_16 = 5'h10;
    localparam logic [TICK_W-1:0] TICKS_17 = 5'h11;
    localparam logic [TICK_W-1:0] SAMPLE_A = 5'h08;
    localparam logic [TICK_W-1:0] SAMPLE_B = 5'h07;
    localparam logic [TICK_W-1:0] SAMPLE_C = 5'h06;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [1:0] NF_OFF = 2'h0;
    localparam logic [1:0] NF_X1 = 2'h1;
    localparam logic [1:0] NF_X2 = 2'h2;
    localparam logic [1:0] BASE_DIV2 = 2'h1;
    localparam logic [1:0] BASE_DIV4 = 2'h2;
    localparam logic [1:0] BASE_DIV8 = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_DATA = 3'b010,
        ST_PAR = 3'b011,
        ST_STOP1 = 3'b100,
        ST_STOP2 = 3'b101
    } usf_state_t;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable_bit;
        logic parity_en;
        logic parity_odd;
        logic stop_bit_count;
        logic infrared_sel;
        logic [1:0] base_clock_sel;
    } usf_ctrl_one_t;

    typedef struct packed {
        logic [2:0] bit_time_sel;
        logic [1:0] rx_noise_filter_sel;
    } usf_ctrl_two_t;

    typedef struct packed {
        logic tx_buf_full_flag;
        logic tx_busy_flag;
        logic rx_buf_full_flag;
        logic parity_err_flag;
        logic framing_err_flag;
        logic overrun_flag;
    } usf_status_t;
endpackage : usf_pkg

// File: verilog/usf_core.sv
// Serial port core: noise filter, transmitter, receiver and status flags.
`timescale 1ns/1ps
module usf_core
    import usf_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Configuration.
    input wire usf_ctrl_one_t CTRL_ONE,
    input wire usf_ctrl_two_t CTRL_TWO,
    input wire logic [DIV_W-1:0] BAUD_DIVISOR,
    input wire logic LOW_POWER,
    // Processor access.
    input wire logic TX_WRITE,
    input wire logic [DATA_W-1:0] TX_DATA,
    input wire logic STATUS_READ,
    input wire logic RX_READ,
    output logic [DATA_W-1:0] RX_DATA,
    output usf_status_t STATUS,
    output logic TX_IRQ,
    output logic RX_IRQ,
    // Serial pins.
    input wire logic RX_PIN,
    output logic TX_PIN
);

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] base_cnt_r;
    logic base_tick;
    logic [DIV_W-1:0] div_cnt_r;
    logic rt_tick;
    logic rx_s1_r;
    logic rx_s2_r;
    logic idle_level;
    logic tx_active;

    assign idle_level = CTRL_ONE.infrared_sel ? 1'b0 : 1'b1;
    assign tx_active = CTRL_ONE.tx_enable && !LOW_POWER;

    // Transfer base clock enable from the system clock.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            base_cnt_r <= 4'h0;
        end else begin
            base_cnt_r <= base_cnt_r + 4'h1;
        end
    end

    always_comb begin
        case (CTRL_ONE.base_clock_sel)
            BASE_DIV2: base_tick = base_cnt_r[0];
            BASE_DIV4: base_tick = &base_cnt_r[1:0];
            BASE_DIV8: base_tick = &base_cnt_r[2:0];
            default: base_tick = 1'b1;
        endcase
    end

    // One tick every (divisor+1) base clocks.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt_r <= '0;
        end else if (base_tick) begin
            div_cnt_r <= (div_cnt_r >= BAUD_DIVISOR) ? '0 : div_cnt_r + 1'b1;
        end
    end
    assign rt_tick = base_tick && (div_cnt_r >= BAUD_DIVISOR);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= RX_PIN;
            rx_s2_r <= rx_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Noise filter: a new level is accepted once it holds for one more than the limit in base clocks.
    logic rx_filt_r;
    logic [DIV_W+3:0] nf_cnt_r;
    logic [DIV_W+3:0] nf_limit;

    always_comb begin
        case (CTRL_TWO.rx_noise_filter_sel)
            NF_X1: nf_limit = {4'h0, BAUD_DIVISOR} + 1'b1;
            NF_X2: nf_limit = ({4'h0, BAUD_DIVISOR} + 1'b1) << 1;
            default: nf_limit = ({4'h0, BAUD_DIVISOR} + 1'b1) << 2;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_filt_r <= 1'b1;
            nf_cnt_r <= '0;
        end else if (CTRL_TWO.rx_noise_filter_sel == NF_OFF) begin
            rx_filt_r <= rx_s2_r;
            nf_cnt_r <= '0;
        end else if (rx_s2_r == rx_filt_r) begin
            nf_cnt_r <= '0;
        end else if (base_tick) begin
            if (nf_cnt_r + 1'b1 > nf_limit) begin
                rx_filt_r <= rx_s2_r;
                nf_cnt_r <= '0;
            end else begin
                nf_cnt_r <= nf_cnt_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ticks per bit, with alternation for the fractional settings.
    function automatic logic [TICK_W-1:0] bit_ticks(input logic [2:0] sel, input logic odd);
        case (sel)
            BT_16_17: bit_ticks = odd ? TICKS_17 : TICKS_16;
            BT_15: bit_ticks = TICKS_15;
            BT_15_16: bit_ticks = odd ? TICKS_16 : TICKS_15;
            BT_17: bit_ticks = TICKS_17;
            default: bit_ticks = TICKS_16;
        endcase
    endfunction : bit_ticks

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter.
    usf_state_t tx_state_r;
    logic [DATA_W-1:0] tx_buf_r;
    logic [DATA_W-1:0] tx_shift_r;
    logic [3:0] tx_bit_r;
    logic [TICK_W-1:0] tx_tick_r;
    logic tx_odd_r;
    logic tx_par_r;
    logic tx_full_r;
    logic tx_busy_r;
    logic tx_start;
    logic tx_bit_end;

    assign tx_start = tx_active && tx_full_r && !TX_WRITE &&
                      (tx_state_r == ST_IDLE || (tx_state_r == ST_STOP2 && tx_bit_end) ||
                       (tx_state_r == ST_STOP1 && tx_bit_end && !CTRL_ONE.stop_bit_count));
    assign tx_bit_end = rt_tick && tx_tick_r == 5'h01;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tx_buf_r <= '0;
            tx_full_r <= 1'b0;
        end else if (TX_WRITE) begin
            tx_buf_r <= TX_DATA;
            tx_full_r <= 1'b1;
        end else if (tx_start) begin
            tx_full_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tx_state_r <= ST_IDLE;
            tx_shift_r <= '0;
            tx_bit_r <= 4'h0;
            tx_tick_r <= TICKS_16;
            tx_odd_r <= 1'b0;
            tx_par_r <= 1'b0;
            tx_busy_r <= 1'b0;
        end else if (!tx_active) begin
            tx_state_r <= ST_IDLE;
            tx_busy_r <= 1'b0;
        end else if (tx_start) begin
            tx_state_r <= ST_START;
            tx_shift_r <= tx_buf_r;
            tx_par_r <= CTRL_ONE.parity_odd;
            tx_bit_r <= 4'h0;
            tx_tick_r <= bit_ticks(CTRL_TWO.bit_time_sel, 1'b0);
            tx_odd_r <= 1'b1;
            tx_busy_r <= 1'b1;
        end else if (tx_state_r != ST_IDLE && rt_tick) begin
            if (tx_tick_r != 5'h01) begin
                tx_tick_r <= tx_tick_r - 1'b1;
            end else begin
                tx_tick_r <= bit_ticks(CTRL_TWO.bit_time_sel, tx_odd_r);
                tx_odd_r <= !tx_odd_r;
                case (tx_state_r)
                    ST_START: tx_state_r <= ST_DATA;
                    ST_DATA: begin
                        tx_par_r <= tx_par_r ^ tx_shift_r[0];
                        tx_shift_r <= tx_shift_r >> 1;
                        tx_bit_r <= tx_bit_r + 4'h1;
                        if (tx_bit_r == DATA_BITS - 4'h1) begin
                            tx_state_r <= CTRL_ONE.parity_en ? ST_PAR : ST_STOP1;
                        end
                    end
                    ST_PAR: tx_state_r <= ST_STOP1;
                    ST_STOP1: begin
                        if (CTRL_ONE.stop_bit_count) begin
                            tx_state_r <= ST_STOP2;
                        end else begin
                            tx_state_r <= ST_IDLE;
                            tx_busy_r <= 1'b0;
                        end
                    end
                    default: begin
                        tx_state_r <= ST_IDLE;
                        tx_busy_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            TX_PIN <= 1'b1;
            TX_IRQ <= 1'b0;
        end else begin
            TX_IRQ <= tx_start;
            case (tx_state_r)
                ST_START: TX_PIN <= !idle_level;
                ST_DATA: TX_PIN <= tx_shift_r[0] ^ CTRL_ONE.infrared_sel;
                ST_PAR: TX_PIN <= tx_par_r ^ CTRL_ONE.infrared_sel;
                default: TX_PIN <= idle_level;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver.
    usf_state_t rx_state_r;
    logic [DATA_W-1:0] rx_shift_r;
    logic [DATA_W-1:0] rx_buf_r;
    logic [3:0] rx_bit_r;
    logic [TICK_W-1:0] rx_tick_r;
    logic [2:0] rx_smp_r;
    logic rx_odd_r;
    logic rx_prev_r;
    logic rx_par_r;
    logic rx_bit_val;
    logic rx_bit_end;
    logic rx_drop_r;
    usf_status_t seen_r;
    usf_status_t st_r;

    assign rx_bit_val = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[0] & rx_smp_r[2]) |
                        (rx_smp_r[1] & rx_smp_r[2]);
    assign rx_bit_end = rt_tick && rx_tick_r == 5'h01;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_state_r <= ST_IDLE;
            rx_shift_r <= '0;
            rx_bit_r <= 4'h0;
            rx_tick_r <= TICKS_16;
            rx_smp_r <= 3'h7;
            rx_odd_r <= 1'b0;
            rx_prev_r <= 1'b1;
            rx_par_r <= 1'b0;
            rx_drop_r <= 1'b0;
        end else begin
            rx_prev_r <= rx_filt_r;
            if (!CTRL_ONE.rx_enable_bit) begin
                rx_state_r <= ST_IDLE;
            end else if (rx_state_r == ST_IDLE) begin
                if (rx_prev_r && !rx_filt_r) begin
                    rx_state_r <= ST_START;
                    rx_tick_r <= bit_ticks(CTRL_TWO.bit_time_sel, 1'b0);
                    rx_odd_r <= 1'b1;
                    rx_bit_r <= 4'h0;
                    rx_par_r <= CTRL_ONE.parity_odd;
                end
            end else if (rt_tick) begin
                if (rx_tick_r == SAMPLE_A || rx_tick_r == SAMPLE_B || rx_tick_r == SAMPLE_C) begin
                    rx_smp_r <= {rx_smp_r[1:0], rx_filt_r};
                end
                if (rx_tick_r != 5'h01) begin
                    rx_tick_r <= rx_tick_r - 1'b1;
                end else begin
                    rx_tick_r <= bit_ticks(CTRL_TWO.bit_time_sel, rx_odd_r);
                    rx_odd_r <= !rx_odd_r;
                    case (rx_state_r)
                        ST_START: rx_state_r <= rx_bit_val ? ST_IDLE : ST_DATA;
                        ST_DATA: begin
                            rx_shift_r <= {rx_bit_val, rx_shift_r[DATA_W-1:1]};
                            rx_par_r <= rx_par_r ^ rx_bit_val;
                            rx_bit_r <= rx_bit_r + 4'h1;
                            if (rx_bit_r == DATA_BITS - 4'h1) begin
                                rx_drop_r <= st_r.rx_buf_full_flag || st_r.overrun_flag;
                                rx_state_r <= CTRL_ONE.parity_en ? ST_PAR : ST_STOP1;
                            end
                        end
                        ST_PAR: begin
                            rx_par_r <= rx_par_r ^ rx_bit_val;
                            rx_state_r <= ST_STOP1;
                        end
                        default: rx_state_r <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // Event strobes from the receiver.
    logic data_done;
    logic frame_done;
    logic load_ok;
    logic par_bad;
    logic frm_bad;
    logic rd_clear;

    assign data_done = rx_state_r == ST_DATA && rx_bit_end && rx_bit_r == DATA_BITS - 4'h1;
    assign frame_done = rx_state_r == ST_STOP1 && rx_bit_end;
    assign load_ok = frame_done && !rx_drop_r;
    assign par_bad = load_ok && CTRL_ONE.parity_en && rx_par_r;
    assign frm_bad = load_ok && !rx_bit_val;
    assign rd_clear = RX_READ;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_buf_r <= '0;
        end else if (load_ok) begin
            rx_buf_r <= rx_shift_r;
        end
    end

    // Flags: a set in the same cycle as a clear wins.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            seen_r <= '0;
        end else if (STATUS_READ) begin
            seen_r <= st_r;
        end else if (rd_clear) begin
            seen_r <= '0;
        end
    end

    logic ovr_set;
    logic rx_full_r;
    logic par_err_r;
    logic frm_err_r;
    logic ovr_r;
    assign ovr_set = data_done && (st_r.rx_buf_full_flag || st_r.overrun_flag) && !st_r.overrun_flag;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_full_r <= 1'b0;
            par_err_r <= 1'b0;
            frm_err_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            if (load_ok) begin
                rx_full_r <= 1'b1;
            end else if (rd_clear && seen_r.rx_buf_full_flag) begin
                rx_full_r <= 1'b0;
            end
            if (par_bad) begin
                par_err_r <= 1'b1;
            end else if (rd_clear && seen_r.parity_err_flag) begin
                par_err_r <= 1'b0;
            end
            if (frm_bad) begin
                frm_err_r <= 1'b1;
            end else if (rd_clear && seen_r.framing_err_flag) begin
                frm_err_r <= 1'b0;
            end
            if (ovr_set) begin
                ovr_r <= 1'b1;
            end else if (rd_clear && seen_r.overrun_flag) begin
                ovr_r <= 1'b0;
            end
        end
    end
    assign st_r = {tx_full_r, tx_busy_r, rx_full_r, par_err_r, frm_err_r, ovr_r};

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            STATUS <= '0;
            RX_IRQ <= 1'b0;
            RX_DATA <= '0;
        end else begin
            STATUS <= st_r;
            RX_IRQ <= load_ok || ovr_set;
            if (rd_clear) begin
                RX_DATA <= seen_r.parity_err_flag ? '0 : rx_buf_r;
            end
        end
    end

endmodule : usf_core

// File: tb/usf_checker.sv
// Concurrent checks on the serial port core's ports.
`timescale 1ns/1ps
module usf_checker
    import usf_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Configuration and access.
    input wire usf_ctrl_one_t CTRL_ONE,
    input wire logic LOW_POWER,
    input wire logic TX_WRITE,
    input wire logic RX_READ,
    // Outputs.
    input wire logic [DATA_W-1:0] RX_DATA,
    input wire usf_status_t STATUS,
    input wire logic TX_IRQ,
    input wire logic RX_IRQ,
    input wire logic TX_PIN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    tx_start_level_a: assert property (TX_IRQ |=> TX_PIN == CTRL_ONE.infrared_sel ##1 !STATUS.tx_buf_full_flag)
        else $error("frame start missing after tx interrupt");
    tx_idle_level_a: assert property (((!CTRL_ONE.tx_enable || LOW_POWER) && $stable(CTRL_ONE)) [*3]
        |-> TX_PIN == !CTRL_ONE.infrared_sel) else $error("tx pin not at idle level");
    tx_busy_set_a: assert property (TX_IRQ |-> ##[1:2] STATUS.tx_busy_flag)
        else $error("busy not set at frame start");
    tx_busy_clear_a: assert property ($fell(STATUS.tx_busy_flag) |-> !STATUS.tx_buf_full_flag)
        else $error("busy cleared with byte waiting");
    tx_full_set_a: assert property (TX_WRITE && STATUS.tx_busy_flag && CTRL_ONE.tx_enable
        |-> ##[1:2] STATUS.tx_buf_full_flag) else $error("write did not set buffer full");
    rx_full_irq_a: assert property ($rose(STATUS.rx_buf_full_flag) |-> ##[0:1] (RX_IRQ || $past(RX_IRQ, 2)))
        else $error("receive buffer loaded without interrupt");
    rx_data_hold_a: assert property (!$stable(RX_DATA) |-> $past(RX_READ))
        else $error("read data changed without a read");
    rx_flag_clear_a: assert property ($fell(STATUS.rx_buf_full_flag) || $fell(STATUS.parity_err_flag)
        || $fell(STATUS.framing_err_flag) || $fell(STATUS.overrun_flag) |-> $past(RX_READ) || $past(RX_READ, 2))
        else $error("receive flag cleared without a read");
    overrun_silent_a: assert property (STATUS.overrun_flag [*3] |-> !RX_IRQ)
        else $error("interrupt raised while overrun held");
    rx_irq_full_a: assert property (RX_IRQ |-> ##[0:2] STATUS.rx_buf_full_flag)
        else $error("receive interrupt without full buffer");
    cover property (STATUS.overrun_flag && STATUS.parity_err_flag);
    cover property ($fell(STATUS.tx_busy_flag));
    cover property (STATUS.framing_err_flag);
endmodule : usf_checker
bind usf_core usf_checker chk_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CTRL_ONE(CTRL_ONE), .LOW_POWER(LOW_POWER),
    .TX_WRITE(TX_WRITE), .RX_READ(RX_READ), .RX_DATA(RX_DATA), .STATUS(STATUS), .TX_IRQ(TX_IRQ),
    .RX_IRQ(RX_IRQ), .TX_PIN(TX_PIN));

// File: tb/usf_peer.sv
// Remote serial peer: sends frames on the receive line and captures frames from the transmit line.
`timescale 1ns/1ps
module usf_peer (
    // Clock.
    input wire logic clk,
    // Serial lines.
    input wire logic tx_line,
    output logic rx_line
);
    int len0 = 16;
    int len1 = 16;
    initial rx_line = 1'b1;
    task automatic hold(input logic v, input int i);
        rx_line = v;
        repeat (i % 2 ? len1 : len0) @(negedge clk);
    endtask : hold
    // Start, eight data bits least significant first, optional parity, one stop, then idle.
    task automatic send(input logic [7:0] d, input logic par_on, input logic par, input logic stop);
        hold(1'b0, 0);
        for (int i = 0; i < 8; i++) hold(d[i], i + 1);
        if (par_on) hold(par, 9);
        hold(stop, par_on ? 10 : 9);
        hold(1'b1, 0);
    endtask : send
    // A short low pulse, then the line rests high.
    task automatic pulse(input int n);
        rx_line = 1'b0;
        repeat (n) @(negedge clk);
        hold(1'b1, 0);
        hold(1'b1, 0);
    endtask : pulse
    // Samples mid-bit: eight data bits, then the bit after them in p.
    task automatic get(output logic [7:0] d, output logic p);
        @(negedge tx_line);
        repeat (len0 / 2) @(negedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat ((len0 + len1) / 2) @(negedge clk);
            if (i < 8) d[i] = tx_line;
            else p = tx_line;
        end
    endtask : get
endmodule : usf_peer

// File: tb/usf_core_test.sv
// Self-checking testbench for the serial port core.
`timescale 1ns/1ps
module usf_core_test;
    import usf_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    usf_ctrl_one_t ctrl_one = '0;
    usf_ctrl_two_t ctrl_two = '0;
    logic [DIV_W-1:0] baud_divisor = '0;
    logic low_power = 1'b0;
    logic tx_write = 1'b0;
    logic [DATA_W-1:0] tx_data = '0;
    logic status_read = 1'b0;
    logic rx_read = 1'b0;
    logic [DATA_W-1:0] rx_data;
    usf_status_t status;
    logic tx_irq;
    logic rx_irq;
    logic rx_pin;
    logic tx_pin;
    int n_errors = 0;
    int samples_checked = 0;
    int n_rx_irq = 0;
    int cycles = 0;
    int la[5] = '{16, 16, 15, 15, 17};
    int lb[5] = '{16, 17, 15, 16, 17};
    logic [7:0] d;
    logic p;
    logic [5:0] s;
    always #5 clk_sys = ~clk_sys;
    usf_core dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .CTRL_ONE(ctrl_one), .CTRL_TWO(ctrl_two),
        .BAUD_DIVISOR(baud_divisor), .LOW_POWER(low_power), .TX_WRITE(tx_write), .TX_DATA(tx_data),
        .STATUS_READ(status_read), .RX_READ(rx_read), .RX_DATA(rx_data), .STATUS(status),
        .TX_IRQ(tx_irq), .RX_IRQ(rx_irq), .RX_PIN(rx_pin), .TX_PIN(tx_pin));
    usf_peer peer_u (.clk(clk_sys), .tx_line(tx_pin), .rx_line(rx_pin));
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        if (rx_irq === 1'b1) n_rx_irq++;
        if (cycles == 60000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] b);
        @(negedge clk_sys);
        tx_write = 1'b1;
        tx_data = b;
        @(negedge clk_sys);
        tx_write = 1'b0;
    endtask : wr
    task automatic rd_status(output logic [5:0] v);
        @(negedge clk_sys);
        status_read = 1'b1;
        v = status;
        @(negedge clk_sys);
        status_read = 1'b0;
    endtask : rd_status
    task automatic rd_buf(output logic [7:0] v);
        @(negedge clk_sys);
        rx_read = 1'b1;
        @(negedge clk_sys);
        rx_read = 1'b0;
        v = rx_data;
    endtask : rd_buf
    task automatic expect_status(input logic [5:0] exp);
        repeat (2) @(negedge clk_sys);
        check({2'h0, status}, {2'h0, exp});
    endtask : expect_status
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk_sys);
        check({2'h0, status}, 8'h00);
        check(tx_pin, 1'b1);
        resetn = 1'b1;
        ctrl_one.tx_enable = 1'b1;
        ctrl_one.rx_enable_bit = 1'b1;
        fork
            begin
                wr(8'ha5);
                repeat (40) @(negedge clk_sys);
                wr(8'h11);
                wr(8'h22);
            end
            begin
                peer_u.get(d, p);
                check(d, 8'ha5);
                check(p, 1'b1);
                peer_u.get(d, p);
                check(d, 8'h22);
            end
        join
        repeat (40) @(negedge clk_sys);
        check(status.tx_busy_flag, 1'b0);
        $display("test tx replace done");
        ctrl_one.parity_en = 1'b1;
        ctrl_one.parity_odd = 1'b1;
        ctrl_one.stop_bit_count = 1'b1;
        check(status.tx_buf_full_flag, 1'b0);
        fork
            wr(8'h35);
            peer_u.get(d, p);
        join
        check(p, ~^8'h35);
        repeat (32) @(negedge clk_sys);
        check(tx_pin, 1'b1);
        check(status.tx_busy_flag, 1'b1);
        repeat (40) @(negedge clk_sys);
        ctrl_one.tx_enable = 1'b0;
        ctrl_one.infrared_sel = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(tx_pin, 1'b0);
        ctrl_one.tx_enable = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(tx_pin, 1'b0);
        ctrl_one.infrared_sel = 1'b0;
        low_power = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(tx_pin, 1'b1);
        low_power = 1'b0;
        ctrl_one.parity_en = 1'b0;
        ctrl_one.stop_bit_count = 1'b0;
        $display("test tx frame done");
        peer_u.send(8'h3c, 1'b0, 1'b0, 1'b1);
        rd_status(s);
        check(s, 6'h08);
        rd_buf(d);
        check(d, 8'h3c);
        expect_status(6'h00);
        peer_u.send(8'h41, 1'b0, 1'b0, 1'b1);
        peer_u.send(8'h42, 1'b0, 1'b0, 1'b1);
        peer_u.send(8'h43, 1'b0, 1'b0, 1'b1);
        check(n_rx_irq[7:0], 8'h03);
        rd_status(s);
        check(s, 6'h09);
        rd_buf(d);
        check(d, 8'h41);
        expect_status(6'h00);
        $display("test overrun done");
        ctrl_one.parity_en = 1'b1;
        ctrl_one.parity_odd = 1'b0;
        rd_status(s);
        peer_u.send(8'h05, 1'b1, 1'b1, 1'b1);
        rd_buf(d);
        expect_status(6'h0c);
        peer_u.send(8'h06, 1'b1, 1'b0, 1'b0);
        rd_status(s);
        check(s, 6'h0d);
        rd_buf(d);
        check(d, 8'h00);
        expect_status(6'h00);
        ctrl_one.parity_en = 1'b0;
        peer_u.send(8'h7e, 1'b0, 1'b0, 1'b0);
        rd_status(s);
        check(s, 6'h0a);
        rd_buf(d);
        check(d, 8'h7e);
        expect_status(6'h00);
        check(n_rx_irq[7:0], 8'h06);
        $display("test receive errors done");
        for (int k = 0; k < 5; k++) begin
            ctrl_two.bit_time_sel = k[2:0];
            ctrl_two.rx_noise_filter_sel = k[1:0];
            baud_divisor = (k == 3) ? 8'h01 : 8'h00;
            ctrl_one.base_clock_sel = (k == 4) ? BASE_DIV2 : 2'h0;
            peer_u.len0 = la[k] * ((k > 2) ? 2 : 1);
            peer_u.len1 = lb[k] * ((k > 2) ? 2 : 1);
            peer_u.pulse(1);
            peer_u.send(8'h90 + k, 1'b0, 1'b0, 1'b1);
            rd_status(s);
            check(s, 6'h08);
            rd_buf(d);
            check(d, 8'h90 + k);
            fork
                wr(8'hc3 - k);
                peer_u.get(d, p);
            join
            check(d, 8'hc3 - k);
            repeat (80) @(negedge clk_sys);
        end
        $display("test bit timing done");
        test_done();
    end
endmodule : usf_core_test
